// ==== inc/supervisor_pkg.sv ====
package supervisor_pkg;

    localparam int unsigned CLK_HZ           = 100_000_000;
    localparam int unsigned CLK_PERIOD_NS    = 10;
    localparam int unsigned HOLD_MS          = 200;
    localparam int unsigned WDOG_MS          = 1600;
    localparam int unsigned GRACE_US         = 10;
    localparam int unsigned KICK_MIN_NS      = 100;
    localparam int unsigned TICK_NS          = 1000;
    localparam int unsigned TICK_CYCLES      = TICK_NS / CLK_PERIOD_NS;
    localparam int unsigned HOLD_TICKS       = HOLD_MS * 1000;
    localparam int unsigned WDOG_TICKS       = WDOG_MS * 1000;
    localparam int unsigned GRACE_TICKS      = GRACE_US;
    localparam int unsigned KICK_MIN_CYCLES  = KICK_MIN_NS / CLK_PERIOD_NS;
    localparam int unsigned CNT_W            = 24;
    localparam int unsigned TICK_W           = 8;

    typedef struct packed {
        logic supply_ok;
        logic above_switchover;
        logic battery_ok;
        logic power_fail_ok;
    } analog_t;

    typedef enum logic [1:0] {
        ST_RUN     = 2'b00,
        ST_HELD    = 2'b01,
        ST_HOLD_LO = 2'b10,
        ST_HOLD_HI = 2'b11
    } rst_state_t;

endpackage : supervisor_pkg

// ==== rtl/sync2.sv ====
`timescale 1ns/1ns
`default_nettype none
module sync2 #(
    parameter int unsigned W = 1
) (
    // Clock and reset
    input  wire logic         core_clk,
    input  wire logic         arst_n,
    // Data
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= din;
            sync_q <= meta_q;
        end
    end

    assign dout = sync_q;
endmodule : sync2
`default_nettype wire

// ==== rtl/tick_gen.sv ====
`timescale 1ns/1ns
`default_nettype none
module tick_gen #(
    parameter int unsigned DIV = supervisor_pkg::TICK_CYCLES
) (
    // Clock and reset
    input  wire logic core_clk,
    input  wire logic arst_n,
    // Tick
    output logic      tick
);
    localparam int unsigned W = supervisor_pkg::TICK_W;
    logic [W-1:0] cnt_q;
    logic [W-1:0] cnt_d;

    always_comb begin
        cnt_d = (cnt_q == W'(DIV - 1)) ? '0 : cnt_q + 1'b1;
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    assign tick = (cnt_q == W'(DIV - 1));
endmodule : tick_gen
`default_nettype wire

// ==== rtl/supply_supervisor_reset_watchdog.sv ====
`timescale 1ns/1ns
`default_nettype none
module supply_supervisor_reset_watchdog #(
    parameter int unsigned HOLD_TICKS  = supervisor_pkg::HOLD_TICKS,
    parameter int unsigned WDOG_TICKS  = supervisor_pkg::WDOG_TICKS,
    parameter int unsigned GRACE_TICKS = supervisor_pkg::GRACE_TICKS,
    parameter int unsigned TICK_DIV    = supervisor_pkg::TICK_CYCLES
) (
    // Clock and reset
    input  wire logic                    core_clk,
    input  wire logic                    arst_n,
    // Analog comparator results
    input  wire supervisor_pkg::analog_t analog_in,
    // Processor side
    input  wire logic                    manual_reset_n,
    input  wire logic                    watchdog_kick_in,
    input  wire logic                    chip_select_in_n,
    output logic                         reset_n_oe,
    output logic                         reset_out,
    output logic                         watchdog_fault_n,
    output logic                         battery_good,
    // Power-fail pin, driven low by this device or by the outside party
    input  wire logic                    power_fail_out_n_i,
    output logic                         power_fail_out_n_o,
    output logic                         power_fail_out_n_oe,
    // RAM side
    output logic                         chip_select_out_n,
    output logic                         backup_connect
);
    localparam int unsigned CW = supervisor_pkg::CNT_W;

    // Pin synchronisation
    supervisor_pkg::analog_t an;
    logic                    mr_n;
    logic                    kick;
    logic                    cs_n;
    logic                    pfo_pin;
    logic [7:0]              sync_in;
    logic [7:0]              sync_out;

    // Comparator lines idle low at reset, so the device powers up in reset
    assign sync_in = {analog_in, manual_reset_n, watchdog_kick_in,
                      chip_select_in_n, power_fail_out_n_i};

    sync2 #(.W(8)) u_sync (
        .core_clk (core_clk),
        .arst_n   (arst_n),
        .din      (sync_in),
        .dout     (sync_out)
    );

    assign an      = sync_out[7:4];
    assign mr_n    = sync_out[3];
    assign kick    = sync_out[2];
    assign cs_n    = sync_out[1];
    assign pfo_pin = sync_out[0];

    logic tick;

    tick_gen #(.DIV(TICK_DIV)) u_tick (
        .core_clk (core_clk),
        .arst_n   (arst_n),
        .tick     (tick)
    );

    // Reset sequencer
    supervisor_pkg::rst_state_t st_q;
    supervisor_pkg::rst_state_t st_d;
    logic [CW-1:0]              hold_q;
    logic [CW-1:0]              hold_d;
    logic                       supply_low;
    logic                       pfo_forced;
    logic                       mr_req;
    logic                       in_reset;
    logic                       first_half;
    logic [1:0]                 own_q;
    logic [1:0]                 own_d;
    logic                       pfo_ext_low;

    assign supply_low = !an.supply_ok || !an.above_switchover;
    assign first_half = (st_q == supervisor_pkg::ST_HOLD_LO);
    // Synchronised pin lags our own pull-down by two cycles; a low level is an
    // outside hold only once our drive has been off that long
    assign pfo_ext_low = !pfo_pin && (own_q == 2'b00);
    assign pfo_forced  = first_half && pfo_ext_low;
    assign mr_req     = !mr_n && !pfo_forced;
    assign in_reset   = (st_q != supervisor_pkg::ST_RUN);

    always_comb begin
        st_d   = st_q;
        hold_d = hold_q;
        case (st_q)
            supervisor_pkg::ST_RUN: begin
                if (supply_low || mr_req) begin
                    st_d   = supervisor_pkg::ST_HELD;
                    hold_d = '0;
                end
            end
            supervisor_pkg::ST_HELD: begin
                hold_d = '0;
                if (!supply_low && !mr_req) begin
                    st_d = supervisor_pkg::ST_HOLD_LO;
                end
            end
            supervisor_pkg::ST_HOLD_LO, supervisor_pkg::ST_HOLD_HI: begin
                if (supply_low || mr_req) begin
                    st_d   = supervisor_pkg::ST_HELD;
                    hold_d = '0;
                end else if (tick) begin
                    hold_d = hold_q + 1'b1;
                    if (hold_q == CW'(HOLD_TICKS / 2 - 1)) begin
                        st_d = supervisor_pkg::ST_HOLD_HI;
                    end
                    if (hold_q == CW'(HOLD_TICKS - 1)) begin
                        st_d = supervisor_pkg::ST_RUN;
                    end
                end
            end
            default: begin
                st_d   = supervisor_pkg::ST_HELD;
                hold_d = '0;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            st_q   <= supervisor_pkg::ST_HELD;
            hold_q <= '0;
        end else begin
            st_q   <= st_d;
            hold_q <= hold_d;
        end
    end

    // Open drain: enable pulls the line low
    assign reset_n_oe = in_reset;
    assign reset_out  = in_reset;

    // Reset-assert timer for the 10 us windows
    logic [CW-1:0] since_q;
    logic [CW-1:0] since_d;
    logic          grace_open;

    assign grace_open = in_reset && (since_q < CW'(GRACE_TICKS));

    always_comb begin
        since_d = since_q;
        if (!in_reset) begin
            since_d = '0;
        end else if (tick && grace_open) begin
            since_d = since_q + 1'b1;
        end
    end

    // Freshness seal
    logic seal_q;
    logic seal_d;
    logic armed_q;
    logic armed_d;

    always_comb begin
        seal_d  = seal_q;
        armed_d = armed_q;
        own_d   = {own_q[0], power_fail_out_n_oe};
        if (first_half && pfo_ext_low) begin
            armed_d = 1'b1;
        end
        if (st_q == supervisor_pkg::ST_RUN && st_d != supervisor_pkg::ST_RUN) begin
            armed_d = 1'b0;
        end
        if (seal_q && an.supply_ok) begin
            seal_d = 1'b0;
        end
        // Seal takes effect when the supply falls after a sealed power-up; set wins
        if (armed_q && st_q == supervisor_pkg::ST_RUN && supply_low) begin
            seal_d = 1'b1;
        end
    end

    assign backup_connect = !seal_q;

    // Watchdog, always on outside reset
    logic [CW-1:0] wd_q;
    logic [CW-1:0] wd_d;
    logic          kick_q;
    logic          fault_q;
    logic          fault_d;
    logic          kick_edge;

    // Synchronised at 10 ns, so 100 ns pulses give at least one edge
    assign kick_edge = kick ^ kick_q;

    always_comb begin
        wd_d    = wd_q;
        fault_d = fault_q;
        if (kick_edge || (in_reset && !grace_open)) begin
            wd_d    = '0;
            fault_d = 1'b0;
        end else if (!in_reset && tick) begin
            if (wd_q == CW'(WDOG_TICKS - 1)) begin
                fault_d = 1'b1;
            end else begin
                wd_d = wd_q + 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            since_q <= '0;
            seal_q  <= 1'b0;
            armed_q <= 1'b0;
            wd_q    <= '0;
            kick_q  <= 1'b0;
            fault_q <= 1'b0;
            own_q   <= 2'b11;
        end else begin
            since_q <= since_d;
            seal_q  <= seal_d;
            armed_q <= armed_d;
            wd_q    <= wd_d;
            kick_q  <= kick;
            fault_q <= fault_d;
            own_q   <= own_d;
        end
    end

    assign watchdog_fault_n = an.above_switchover && !fault_q;
    assign battery_good     = an.above_switchover && an.battery_ok;

    // Power-fail output, first half forced high
    assign power_fail_out_n_o  = 1'b0;
    assign power_fail_out_n_oe = !first_half && (!an.power_fail_ok || !an.above_switchover);

    // Chip-select gating
    logic cs_hold_q;
    logic cs_hold_d;
    logic cs_q;
    logic cs_d;

    always_comb begin
        cs_hold_d = cs_hold_q;
        if (!in_reset) begin
            cs_hold_d = !cs_n;
        end else if (cs_n || !grace_open || first_half && since_q >= CW'(GRACE_TICKS)) begin
            cs_hold_d = 1'b0;
        end
        cs_d = 1'b1;
        if (!in_reset) begin
            cs_d = cs_n;
        end else if (cs_hold_q && !cs_n && grace_open) begin
            cs_d = 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            cs_hold_q <= 1'b0;
            cs_q      <= 1'b1;
        end else begin
            cs_hold_q <= cs_hold_d;
            cs_q      <= cs_d;
        end
    end

    assign chip_select_out_n = cs_q;

    AST_RST_INV: assert property (@(posedge core_clk) disable iff (!arst_n)
        reset_out == reset_n_oe) else $error("active-high reset not inverse");

    AST_SUPPLY_LOW: assert property (@(posedge core_clk) disable iff (!arst_n)
        supply_low |=> reset_out) else $error("reset missing on supply low");

    AST_MR_RESET: assert property (@(posedge core_clk) disable iff (!arst_n)
        (!mr_n && !first_half) |=> reset_out) else $error("manual reset ignored");

    sequence s_release;
        $fell(reset_out);
    endsequence

    AST_HOLD_FULL: assert property (@(posedge core_clk) disable iff (!arst_n)
        s_release |-> $past(hold_q) == CW'(HOLD_TICKS - 1)) else $error("reset released early");

    AST_CS_BLOCK: assert property (@(posedge core_clk) disable iff (!arst_n)
        (first_half && since_q >= CW'(GRACE_TICKS)) |=> chip_select_out_n)
        else $error("chip select passed in first half");

    AST_CS_PASS: assert property (@(posedge core_clk) disable iff (!arst_n)
        (!in_reset && !$past(in_reset)) |=> chip_select_out_n == $past(cs_n))
        else $error("chip select not passed");

    AST_WD_CLEAR: assert property (@(posedge core_clk) disable iff (!arst_n)
        kick_edge |=> (wd_q == '0 && !fault_q)) else $error("kick did not clear watchdog");

    AST_BACKUP_SUPPLY_IN_SW: assert property (@(posedge core_clk) disable iff (!arst_n)
        !an.above_switchover |-> (!battery_good && !watchdog_fault_n))
        else $error("outputs not low below switchover");

    AST_PFO_FORCE: assert property (@(posedge core_clk) disable iff (!arst_n)
        first_half |-> !power_fail_out_n_oe) else $error("power-fail driven in first half");

    AST_WD_HOLD: assert property (@(posedge core_clk) disable iff (!arst_n)
        (in_reset && !grace_open) |=> wd_q == '0) else $error("watchdog counts in reset");
endmodule : supply_supervisor_reset_watchdog
`default_nettype wire

// ==== bench/cpu_model.sv ====
`timescale 1ns/1ns
`default_nettype none
module cpu_model (
    // Clock
    input  wire logic       core_clk,
    // Commands from the bench
    input  wire logic       kick_en,
    input  wire logic [7:0] kick_gap,
    input  wire logic       cs_req_n,
    input  wire logic       seal_req,
    // Pins toward the supervisor
    output logic            watchdog_kick_in,
    output logic            chip_select_in_n,
    output logic            pfo_pull
);
    logic [7:0] cnt_q;

    initial begin
        cnt_q = 8'h00;
        watchdog_kick_in = 1'b0;
    end

    // Kick is a 100 ns high pulse, so each kick gives two edges
    always @(posedge core_clk) begin
        cnt_q <= (!kick_en || cnt_q >= kick_gap) ? 8'h00 : cnt_q + 8'h01;
        watchdog_kick_in <= kick_en && (cnt_q < 8'h0A);
    end

    assign chip_select_in_n = cs_req_n;
    // Pin is pulled low from outside to arm the seal
    assign pfo_pull = seal_req;
endmodule : cpu_model
`default_nettype wire

// ==== bench/supply_supervisor_reset_watchdog_tb.sv ====
`timescale 1ns/1ns
`default_nettype none
module supply_supervisor_reset_watchdog_tb;
    localparam int HT = 20;
    localparam int WT = 50;
    localparam int GT = 2;
    localparam int TD = 4;
    logic core_clk, arst_n, mr_q, tie_q, kick_en, cs_req_n, seal_req, pfo_pull;
    logic kick, cs_in, rst_oe, rst_out, wfault_n, bgood, pfo_o, pfo_oe, cs_out, bk_con;
    logic       manual_reset_n;
    logic       pfo_pin;
    logic [7:0] kick_gap;
    logic [31:0] seed;
    int          error_cnt;
    int          comparisons;
    int          w;
    supervisor_pkg::analog_t ana;

    assign manual_reset_n = mr_q & (~tie_q | wfault_n);
    // Open-drain pin with pull-up: low if either party pulls
    assign pfo_pin = (pfo_oe ? pfo_o : 1'b1) & ~pfo_pull;

    supply_supervisor_reset_watchdog #(
        .HOLD_TICKS(HT), .WDOG_TICKS(WT), .GRACE_TICKS(GT), .TICK_DIV(TD)
    ) DUT (
        .core_clk(core_clk), .arst_n(arst_n), .analog_in(ana),
        .manual_reset_n(manual_reset_n), .watchdog_kick_in(kick),
        .chip_select_in_n(cs_in), .reset_n_oe(rst_oe), .reset_out(rst_out),
        .watchdog_fault_n(wfault_n), .battery_good(bgood),
        .power_fail_out_n_i(pfo_pin), .power_fail_out_n_o(pfo_o),
        .power_fail_out_n_oe(pfo_oe), .chip_select_out_n(cs_out),
        .backup_connect(bk_con)
    );

    cpu_model cpu (
        .core_clk(core_clk), .kick_en(kick_en), .kick_gap(kick_gap),
        .cs_req_n(cs_req_n), .seal_req(seal_req), .watchdog_kick_in(kick),
        .chip_select_in_n(cs_in), .pfo_pull(pfo_pull)
    );

    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd

    function automatic logic exp_bgood(input supervisor_pkg::analog_t a);
        return a.above_switchover & a.battery_ok;
    endfunction : exp_bgood

    // Outputs are read 1 ns after the edge so its updates have landed
    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : cyc

    task automatic chk(input logic got, input logic exp);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic finish_test();
        $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : finish_test

    // Whole run needs about 1700 cycles
    initial begin
        repeat (20000) @(posedge core_clk);
        error_cnt++;
        finish_test();
    end

    initial begin
        seed = 32'h0000_0029;
        error_cnt = 0;
        comparisons = 0;
        arst_n = 1'b0;
        ana = 4'hE;
        mr_q = 1'b1;
        tie_q = 1'b0;
        kick_en = 1'b0;
        kick_gap = 8'h28;
        cs_req_n = 1'b1;
        seal_req = 1'b0;
        repeat (16) @(posedge core_clk);
        arst_n <= 1'b1;
        cyc(20);
        chk(pfo_pin, 1'b1);
        cyc(40);
        chk(rst_out, 1'b1);
        chk(pfo_pin, 1'b0);
        cyc(40);
        chk(rst_out, 1'b0);
        chk(rst_oe, 1'b0);
        @(posedge core_clk) ana.power_fail_ok <= 1'b1;
        kick_en <= 1'b1;
        // Random traffic; kick spacing always inside the timeout
        for (int i = 0; i < 30; i++) begin
            @(posedge core_clk);
            ana.battery_ok <= 1'(rnd());
            cs_req_n <= 1'(rnd());
            kick_gap <= 8'h14 + 8'(rnd() % 100);
            cyc(6);
            chk(bgood, exp_bgood(ana));
            chk(cs_out, cs_req_n);
            chk(wfault_n, 1'b1);
        end
        // Manual reset held beyond the watchdog period
        @(posedge core_clk) kick_en <= 1'b0;
        cs_req_n <= 1'b1;
        mr_q <= 1'b0;
        cyc(5);
        chk(rst_out, 1'b1);
        cyc(250);
        chk(wfault_n, 1'b1);
        @(posedge core_clk) mr_q <= 1'b1;
        cs_req_n <= 1'b0;
        cyc(30);
        chk(cs_out, 1'b1);
        cyc(30);
        chk(rst_out, 1'b1);
        cyc(40);
        chk(rst_out, 1'b0);
        chk(cs_out, 1'b0);
        cyc(140);
        chk(wfault_n, 1'b1);
        cyc(80);
        chk(wfault_n, 1'b0);
        @(posedge core_clk) kick_en <= 1'b1;
        cyc(8);
        chk(wfault_n, 1'b1);
        // Supply drop in mid-write, then a brownout during the hold
        @(posedge core_clk) ana.supply_ok <= 1'b0;
        cyc(5);
        chk(rst_out, 1'b1);
        chk(cs_out, 1'b0);
        cyc(15);
        chk(cs_out, 1'b1);
        @(posedge core_clk) ana.supply_ok <= 1'b1;
        cyc(40);
        @(posedge core_clk) ana.supply_ok <= 1'b0;
        cyc(5);
        @(posedge core_clk) ana.supply_ok <= 1'b1;
        cyc(60);
        chk(rst_out, 1'b1);
        cyc(40);
        chk(rst_out, 1'b0);
        // Below switchover level
        @(posedge core_clk) ana.above_switchover <= 1'b0;
        ana.battery_ok <= 1'b1;
        cyc(5);
        chk(rst_out, 1'b1);
        chk(bgood, 1'b0);
        chk(wfault_n, 1'b0);
        @(posedge core_clk) ana.above_switchover <= 1'b1;
        cyc(100);
        // Fault output looped to manual reset gives a short pulse
        @(posedge core_clk) tie_q <= 1'b1;
        kick_en <= 1'b0;
        w = 0;
        while (wfault_n !== 1'b0 && w < 400) begin
            cyc(1);
            w++;
        end
        w = 0;
        while (wfault_n === 1'b0 && w < 100) begin
            cyc(1);
            w++;
        end
        chk(w >= GT * TD && w <= GT * TD + 12, 1'b1);
        chk(rst_out, 1'b1);
        @(posedge core_clk) tie_q <= 1'b0;
        kick_en <= 1'b1;
        cyc(100);
        // Seal arming with a manual-reset pulse in the first half
        @(posedge core_clk) ana.supply_ok <= 1'b0;
        cyc(10);
        @(posedge core_clk) seal_req <= 1'b1;
        ana.supply_ok <= 1'b1;
        cyc(10);
        @(posedge core_clk) mr_q <= 1'b0;
        cyc(10);
        @(posedge core_clk) mr_q <= 1'b1;
        cyc(75);
        chk(rst_out, 1'b0);
        @(posedge core_clk) seal_req <= 1'b0;
        ana.supply_ok <= 1'b0;
        cyc(8);
        chk(bk_con, 1'b0);
        @(posedge core_clk) ana.supply_ok <= 1'b1;
        cyc(8);
        chk(bk_con, 1'b1);
        finish_test();
    end
endmodule : supply_supervisor_reset_watchdog_tb
`default_nettype wire
